// file: rtl/dpd_pkg.sv
// Shared constants and types for the display power-down controller.
package dpd_pkg;
  // Register indices on the plain register port.
  localparam logic [1:0] DPD_OFS_MODE   = 2'h0;  // Power mode control.
  localparam logic [1:0] DPD_OFS_COUNT  = 2'h1;  // Power-down refresh count.
  localparam logic [1:0] DPD_OFS_RPL    = 2'h2;  // Refresh per line select.
  localparam logic [1:0] DPD_OFS_STATUS = 2'h3;  // Read-only state.
  // Field positions.
  localparam int DPD_BIT_SLEEP = 7;  // Sleep select in mode register.
  localparam int DPD_BIT_IDIV  = 6;  // Internal divide in mode register.
  localparam int DPD_BIT_GEN   = 7;  // General mode in count register.
  // Values after reset.
  localparam logic [7:0] DPD_RST_MODE  = 8'h00;
  localparam logic [7:0] DPD_RST_COUNT = 8'h00;
  localparam logic [1:0] DPD_RST_RPL   = 2'h1;
  // Cycle counts of the sequencing.
  localparam logic [2:0] DPD_DLY_LINES = 3'h4;  // Scan lines of entry or exit delay.
  localparam logic [1:0] DPD_DLY_REFS  = 2'h3;  // Refresh pulses after those lines.
  localparam logic [2:0] DPD_DIV_LAST  = 3'h7;  // Divide by eight, last phase.
  localparam logic [7:0] DPD_CNT_BIAS  = 8'h05;  // Offset added back to the count.
  localparam logic [1:0] DPD_RPL_TWO   = 2'h3;  // Two refreshes per line.
  // Controller states, one-hot.
  typedef enum logic [6:0] {
    DPD_NORMAL  = 7'h01,
    DPD_SL_ENTR = 7'h02,
    DPD_SLEEP   = 7'h04,
    DPD_SL_EXIT = 7'h08,
    DPD_IDLE    = 7'h10,
    DPD_GEN_EXT = 7'h20,
    DPD_GEN_INT = 7'h40
  } dpd_state_t;
  // Memory control pins that are forced during sleep.
  typedef struct packed {
    logic       oe_low;   // Output enable, low byte pair.
    logic       oe_high;  // Output enable, high byte pair.
    logic [3:0] we;       // Write enables.
    logic [8:0] addr;     // Memory address lines.
  } dpd_mem_ctl_t;
endpackage : dpd_pkg

// file: rtl/dpd_power_down_control.sv
// Power-down mode controller: sleep, display idle and the two general modes.
//
// Operation
// RL1: Software sets sleep select before sleep.
// RL2: Sleep refuses all host I/O and memory.
// RL3: Sleep stops clocks after four lines, three refreshes.
// RL4: Sleep: DAC off, only CBR refresh per pulse.
// RL5: Outside keeps video clock at least 8 KHz.
// RL6: Manager slows clocks only after entry delay.
// RL7: Sleep drives enables and address lines high.
// RL8: Manager restores clocks before releasing request.
// RL9: Sleep exit resumes after four lines, three refreshes.
// RL10: Host reloads palette and dithering table after.
// RL11: Idle chosen by both mode bits zero.
// RL12: Idle divides clocks by eight, display off.
// RL13: Idle uses CBR refresh, no arbitration.
// RL14: Idle allows I/O, rejects display memory.
// RL15: Request high ends idle; clocks stay full.
// RL16: External general mode needs preloaded refresh count.
// RL17: General modes time refresh from count register.
// RL18: General plus divide bit divides by eight.
// RL19: General modes: display off, host access allowed.
// RL20: Manager restores clocks before leaving external general.
// RL21: Request high restores full clocks in general.
// RL22: Count equals period over character clock minus five.
// RL23: Select 01 one refresh, 11 two.
// RL24: Sleep select wins over other mode bits.
// RL25: Request pin is synchronised before use.
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
module dpd_power_down_control
  import dpd_pkg::*;
(
  input  wire logic         core_clk_i,              // Core clock, 100 MHz.
  input  wire logic         resetn_i,                // Asynchronous reset, active low.
  input  wire logic         power_down_request_n_i,  // Pin from the power manager.
  input  wire logic         refresh_i,               // Refresh pulse pin.
  input  wire logic         line_end_i,              // One pulse per scan line.
  input  wire dpd_mem_ctl_t mem_normal_i,            // Memory pins in normal use.
  input  wire logic [1:0]   reg_addr_i,              // Register index.
  input  wire logic [7:0]   reg_wdata_i,             // Register write data.
  input  wire logic         reg_wr_i,                // Write strobe.
  input  wire logic         reg_rd_i,                // Read strobe.
  output logic [7:0]        reg_rdata_o,             // Read data, one cycle later.
  output dpd_mem_ctl_t      mem_ctl_o,               // Memory pins as driven.
  output logic              int_clk_en_o,            // Internal clock enable.
  output logic              display_on_o,            // Display and panel on.
  output logic              dac_on_o,                // Palette and DAC on.
  output logic              arbitration_en_o,        // Host/display/refresh arbitration.
  output logic              refresh_src_count_o,     // Refresh timed by the count.
  output logic              cbr_refresh_cycle_o,     // One CBR refresh cycle.
  output logic              count_refresh_o,         // Count timer refresh request.
  output logic [1:0]        refresh_burst_o,         // Refreshes per count request.
  output logic              host_io_allow_o,         // Host may reach I/O registers.
  output logic              host_mem_allow_o         // Host may reach display memory.
);

  // Software-visible registers.
  logic [7:0] power_mode_control_reg;   // Sleep select and divide bit.
  logic [7:0] powerdown_refresh_count;  // General bit and refresh count.
  logic [1:0] refresh_per_line_select;  // Refreshes per line.
  // Synchronisers and filtered levels of the two pins.
  logic [2:0] req_sync;   // Request pin stages.
  logic [2:0] ref_sync;   // Refresh pin stages.
  logic       req_low;    // Filtered request, high means power down asked.
  logic       ref_lvl;    // Filtered refresh level.
  logic       ref_lvl_q;  // Refresh level one cycle late.
  logic       ref_edge;   // Rising edge of the refresh pin.
  // Sequencing state.
  dpd_state_t st;              // Current mode.
  dpd_state_t next_st;         // Mode after this edge.
  logic [2:0] dly_lines;       // Lines seen in the entry or exit delay.
  logic [1:0] dly_refs;        // Refresh pulses seen after the lines.
  logic       dly_done;        // Entry or exit delay complete.
  logic [2:0] div_cnt;         // Divide-by-eight phase.
  logic [2:0] chr_cnt;         // Internal clocks within a character.
  logic [7:0] rfc_cnt;         // Characters since the last count refresh.
  logic       int_tick;        // Internal clock enable this cycle.
  logic       chr_tick;        // End of one character clock.
  logic       in_sleep;        // Any sleep state.
  logic       in_general;      // Either general state.
  // Register writes; only the strobe and index steer them.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      power_mode_control_reg  <= DPD_RST_MODE;
      powerdown_refresh_count <= DPD_RST_COUNT;
      refresh_per_line_select <= DPD_RST_RPL;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        DPD_OFS_MODE:  power_mode_control_reg  <= reg_wdata_i;
        DPD_OFS_COUNT: powerdown_refresh_count <= reg_wdata_i;
        DPD_OFS_RPL:   refresh_per_line_select <= reg_wdata_i[1:0];
        default: begin
          // The status index is read only; writes to it are dropped.
        end
      endcase
    end
  end

  // Read data stands in the cycle after the strobe and only there.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        DPD_OFS_MODE:   reg_rdata_o <= power_mode_control_reg;
        DPD_OFS_COUNT:  reg_rdata_o <= powerdown_refresh_count;
        DPD_OFS_RPL:    reg_rdata_o <= {6'h00, refresh_per_line_select};
        DPD_OFS_STATUS: reg_rdata_o <= {req_low, st};
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // Three-stage pin capture; a level counts once the last two stages agree.
  // The first stage feeds only the second, so metastability stays contained.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      req_sync  <= 3'h7;
      ref_sync  <= 3'h0;
      req_low   <= 1'b0;
      ref_lvl   <= 1'b0;
      ref_lvl_q <= 1'b0;
    end else begin
      req_sync <= {req_sync[1:0], power_down_request_n_i};  // RL25
      ref_sync <= {ref_sync[1:0], refresh_i};
      // A glitch seen by one stage only is ignored.
      if (req_sync[1] == req_sync[2]) begin
        req_low <= ~req_sync[2];  // RL25
      end
      if (ref_sync[1] == ref_sync[2]) begin
        ref_lvl <= ref_sync[2];
      end
      ref_lvl_q <= ref_lvl;
    end
  end

  assign ref_edge = ref_lvl & ~ref_lvl_q;
  // Delay of four lines followed by three refresh pulses, used on entry and exit.
  assign dly_done = (dly_lines == DPD_DLY_LINES) && (dly_refs == DPD_DLY_REFS);
  // Mode selection; the sleep bit is tested first so it overrides the rest.
  always_comb begin
    next_st = st;
    unique case (st)
      DPD_NORMAL: begin
        if (req_low) begin
          if (power_mode_control_reg[DPD_BIT_SLEEP]) begin
            next_st = DPD_SL_ENTR;  // RL24
          end else if (!powerdown_refresh_count[DPD_BIT_GEN]) begin
            next_st = DPD_IDLE;
          end else if (power_mode_control_reg[DPD_BIT_IDIV]) begin
            next_st = DPD_GEN_INT;  // RL18
          end else begin
            next_st = DPD_GEN_EXT;
          end
        end
      end
      DPD_SL_ENTR: begin
        // Clocks stop only when the full delay has run.
        if (dly_done) begin
          next_st = DPD_SLEEP;  // RL3
        end
      end
      DPD_SLEEP: begin
        if (!req_low) begin
          next_st = DPD_SL_EXIT;
        end
      end
      DPD_SL_EXIT: begin
        if (dly_done) begin
          next_st = DPD_NORMAL;  // RL9
        end
      end
      DPD_IDLE, DPD_GEN_EXT, DPD_GEN_INT: begin
        // Idle and general modes end as soon as the request rises.
        if (!req_low) begin
          next_st = DPD_NORMAL;  // RL15 RL21
        end
      end
    endcase
  end

  // State register.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st <= DPD_NORMAL;
    end else begin
      st <= next_st;
    end
  end

  // Delay counters; they restart whenever a delay state is entered.
  // Line pulses are counted on the core clock while internal clocks still run at full rate.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dly_lines <= 3'h0;
      dly_refs  <= 2'h0;
    end else if ((st != DPD_SL_ENTR) && (st != DPD_SL_EXIT)) begin
      dly_lines <= 3'h0;
      dly_refs  <= 2'h0;
    end else if (dly_lines != DPD_DLY_LINES) begin
      if (line_end_i) begin
        dly_lines <= dly_lines + 3'h1;  // RL3 RL9
      end
    end else if (ref_edge && (dly_refs != DPD_DLY_REFS)) begin
      dly_refs <= dly_refs + 2'h1;  // RL3 RL9
    end
  end

  assign in_sleep   = (st == DPD_SL_ENTR) || (st == DPD_SLEEP) || (st == DPD_SL_EXIT);
  assign in_general = (st == DPD_GEN_EXT) || (st == DPD_GEN_INT);
  // Divide-by-eight phase for idle and internal general mode.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_cnt <= 3'h0;
    end else if ((st == DPD_IDLE) || (st == DPD_GEN_INT)) begin
      div_cnt <= div_cnt + 3'h1;  // RL12 RL18
    end else begin
      div_cnt <= 3'h0;
    end
  end

  // Internal clocks run fully, one in eight, or not at all in deep sleep.
  always_comb begin
    if (st == DPD_SLEEP) begin
      int_tick = 1'b0;  // RL3
    end else if ((st == DPD_IDLE) || (st == DPD_GEN_INT)) begin
      int_tick = (div_cnt == DPD_DIV_LAST);  // RL12 RL18
    end else begin
      int_tick = 1'b1;  // RL21
    end
  end

  assign chr_tick = int_tick && (chr_cnt == DPD_DIV_LAST);
  // Count-based refresh timer: a request every count plus five characters.
  // The bias restores the offset that software subtracted from the period.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      chr_cnt         <= 3'h0;
      rfc_cnt         <= 8'h00;
      count_refresh_o <= 1'b0;
    end else if (!in_general) begin
      chr_cnt         <= 3'h0;
      rfc_cnt         <= 8'h00;
      count_refresh_o <= 1'b0;
    end else begin
      count_refresh_o <= 1'b0;
      if (int_tick) begin
        chr_cnt <= chr_cnt + 3'h1;
      end
      if (chr_tick) begin
        if (rfc_cnt >= ({1'b0, powerdown_refresh_count[6:0]} + DPD_CNT_BIAS - 8'h01)) begin
          rfc_cnt         <= 8'h00;
          count_refresh_o <= 1'b1;  // RL17 RL22
        end else begin
          rfc_cnt <= rfc_cnt + 8'h01;
        end
      end
    end
  end

  // Refresh cycles per request; undefined codes fall back to one.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      refresh_burst_o <= 2'h1;
    end else if (refresh_per_line_select == DPD_RPL_TWO) begin
      refresh_burst_o <= 2'h2;  // RL23
    end else begin
      refresh_burst_o <= 2'h1;  // RL23
    end
  end

  // CBR refresh cycles follow the refresh pin in sleep and idle.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cbr_refresh_cycle_o <= 1'b0;
    end else begin
      cbr_refresh_cycle_o <= ref_edge && (in_sleep || (st == DPD_IDLE));  // RL4 RL13
    end
  end

  // Memory pins are held high in sleep; the data bus is left to the owner.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mem_ctl_o <= '1;
    end else if (st == DPD_SLEEP) begin
      mem_ctl_o <= '1;  // RL7
    end else begin
      mem_ctl_o <= mem_normal_i;
    end
  end

  // Unit enables; the display shows only in normal operation.
  assign display_on_o        = (st == DPD_NORMAL);  // RL12 RL19
  assign dac_on_o            = (st == DPD_NORMAL);  // RL4
  assign arbitration_en_o    = (st != DPD_IDLE) && (st != DPD_SLEEP);  // RL13
  assign refresh_src_count_o = in_general;  // RL17
  assign int_clk_en_o        = int_tick;
  // Sleep locks the host out from the cycle after the request is seen.
  assign host_io_allow_o     = !in_sleep;  // RL2 RL14 RL19
  assign host_mem_allow_o    = !in_sleep && (st != DPD_IDLE);  // RL2 RL14 RL19

  // The lockout is judged from the request itself, so a broken state chain shows up.
  AST_SLEEP_LOCKOUT: assert property (@(posedge core_clk_i) disable iff (!resetn_i)  // RL2
    (st == DPD_NORMAL) && req_low && power_mode_control_reg[DPD_BIT_SLEEP] |=>
      !host_io_allow_o && !host_mem_allow_o)
    else $error("Host access allowed during sleep.");
  AST_SLEEP_DELAY: assert property (@(posedge core_clk_i) disable iff (!resetn_i)  // RL3
    (st == DPD_SL_ENTR) ##1 (st == DPD_SLEEP) |->
      ($past(dly_lines) == 3'h4) && ($past(dly_refs) == 2'h3) && !int_clk_en_o)
    else $error("Clocks stopped before the entry delay ran.");
  AST_CBR_PULSE: assert property (@(posedge core_clk_i) disable iff (!resetn_i)  // RL4
    ref_edge && (st == DPD_SLEEP) |=> cbr_refresh_cycle_o && !dac_on_o)
    else $error("Refresh pulse gave no CBR cycle in sleep.");
  AST_SLEEP_PINS: assert property (@(posedge core_clk_i) disable iff (!resetn_i)  // RL7
    (st == DPD_SLEEP) ##1 (st == DPD_SLEEP) |-> (mem_ctl_o == 15'h7FFF))
    else $error("Memory pins not high in sleep.");
  AST_EXIT_DELAY: assert property (@(posedge core_clk_i) disable iff (!resetn_i)  // RL9
    (st == DPD_SL_EXIT) ##1 (st == DPD_NORMAL) |-> ($past(dly_refs) == 2'h3))
    else $error("Sleep exit ended early.");
  AST_IDLE_DIVIDE: assert property (@(posedge core_clk_i) disable iff (!resetn_i)  // RL12
    (st == DPD_IDLE) && int_clk_en_o ##1 (st == DPD_IDLE) [*7] |->
      !$past(int_clk_en_o) && !display_on_o)
    else $error("Idle clock not divided by eight.");
  AST_IDLE_ACCESS: assert property (@(posedge core_clk_i) disable iff (!resetn_i)  // RL14
    (st == DPD_IDLE) |-> host_io_allow_o && !host_mem_allow_o && !arbitration_en_o)
    else $error("Idle access gating wrong.");
  AST_GENERAL: assert property (@(posedge core_clk_i) disable iff (!resetn_i)  // RL19
    in_general |-> host_io_allow_o && host_mem_allow_o && !display_on_o && refresh_src_count_o)
    else $error("General mode gating wrong.");
  AST_SLEEP_FIRST: assert property (@(posedge core_clk_i) disable iff (!resetn_i)  // RL24
    (st == DPD_NORMAL) && req_low && power_mode_control_reg[7] |=> (st == DPD_SL_ENTR))
    else $error("Sleep select did not take priority.");
  AST_GEN_RELEASE: assert property (@(posedge core_clk_i) disable iff (!resetn_i)  // RL21
    (st == DPD_GEN_INT) && !req_low |=> (st == DPD_NORMAL) && int_clk_en_o)
    else $error("General mode did not restore full clocks.");

endmodule : dpd_power_down_control

// file: test/dpd_power_manager_model.sv
// Behavioural power manager: request pin, refresh pin and scan-line ticks.
`timescale 1ns/1ps
module dpd_power_manager_model
  import dpd_pkg::*;
(
  input  wire logic core_clk_i,             // Core clock.
  input  wire logic resetn_i,               // Reset, active low.
  input  wire logic pd_cmd_i,               // Bench asks for power-down.
  output logic      power_down_request_n_o, // Request pin, active low.
  output logic      refresh_o,              // Refresh pin, period of 40 cycles.
  output logic      line_end_o              // One-cycle tick every 16 cycles.
);
  logic [5:0] ref_cnt;   // Refresh period counter.
  logic [3:0] line_cnt;  // Scan-line counter, wraps by itself.
  // The clocks are never slowed by this model, so they are at full rate and
  // stable whenever the request is raised, and never slowed too early.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ref_cnt                <= 6'h00;
      line_cnt               <= 4'h0;
      refresh_o              <= 1'b0;
      line_end_o             <= 1'b0;
      power_down_request_n_o <= 1'b1;
    end else begin
      ref_cnt                <= (ref_cnt == 6'h27) ? 6'h00 : ref_cnt + 6'h01;
      line_cnt               <= line_cnt + 4'h1;
      refresh_o              <= (ref_cnt < 6'h14);
      line_end_o             <= (line_cnt == 4'hF);
      power_down_request_n_o <= !pd_cmd_i;
    end
  end
endmodule : dpd_power_manager_model

// file: test/dpd_power_down_control_bench.sv
// Self-checking bench for the display power-down controller.
`timescale 1ns/1ps
module dpd_power_down_control_bench
  import dpd_pkg::*;
;
  logic         core_clk_i;  // Core clock.
  logic         resetn_i;    // Reset, active low.
  logic         pd_cmd;      // Power-down command to the manager model.
  logic         req_n;       // Request pin.
  logic         refresh;     // Refresh pin.
  logic         line_end;    // Scan-line tick.
  dpd_mem_ctl_t mem_normal;  // Memory pins in normal use.
  dpd_mem_ctl_t mem_ctl;     // Memory pins as driven.
  logic [1:0]   reg_addr;    // Register index.
  logic [7:0]   reg_wdata;   // Write data.
  logic         reg_wr;      // Write strobe.
  logic         reg_rd;      // Read strobe.
  logic [7:0]   reg_rdata;   // Read data.
  logic         clk_en, disp_on, dac_on, arb_en, src_cnt, cbr, cnt_ref, io_ok, mem_ok;
  logic [1:0]   burst;       // Refreshes per count request.
  int           errors;
  int           compares;

  dpd_power_manager_model pm (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .pd_cmd_i(pd_cmd), .power_down_request_n_o(req_n), .refresh_o(refresh),
    .line_end_o(line_end));

  dpd_power_down_control uut (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .power_down_request_n_i(req_n), .refresh_i(refresh), .line_end_i(line_end),
    .mem_normal_i(mem_normal), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .mem_ctl_o(mem_ctl),
    .int_clk_en_o(clk_en), .display_on_o(disp_on), .dac_on_o(dac_on),
    .arbitration_en_o(arb_en), .refresh_src_count_o(src_cnt), .cbr_refresh_cycle_o(cbr),
    .count_refresh_o(cnt_ref), .refresh_burst_o(burst), .host_io_allow_o(io_ok),
    .host_mem_allow_o(mem_ok));

  // Clock of 10 ns period.
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  // Compares one value and counts the result.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // One-cycle write strobe.
  task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk_i);
    reg_wr <= 1'b0;
    #1;
  endtask : reg_write

  // One-cycle read strobe; data is taken in the following cycle only.
  task automatic reg_read(input logic [1:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk_i);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : reg_read

  // Polls the status register until it shows the expected state, bounded.
  task automatic wait_status(input logic [7:0] exp);
    logic [7:0] d;
    int         n;
    d = 8'h00;
    n = 0;
    while (d !== exp && n < 60) begin
      reg_read(DPD_OFS_STATUS, d);
      n++;
    end
    check({8'h00, d}, {8'h00, exp}, "status");
  endtask : wait_status

  // Counts cycles with the clock enable high over 16 cycles.
  task automatic en_ones(output int ones);
    ones = 0;
    repeat (16) begin
      @(posedge core_clk_i);
      #1;
      if (clk_en === 1'b1) ones++;
    end
  endtask : en_ones

  // Cycles from now to the next count-timer request, bounded.
  task automatic gap(output int n);
    n = 0;
    do begin
      @(posedge core_clk_i);
      #1;
      n++;
    end while (cnt_ref !== 1'b1 && n < 2000);
  endtask : gap

  task automatic test_reset();
    logic [7:0] d;
    reg_read(DPD_OFS_MODE, d);
    check({8'h00, d}, {8'h00, DPD_RST_MODE}, "mode reset");
    reg_read(DPD_OFS_COUNT, d);
    check({8'h00, d}, {8'h00, DPD_RST_COUNT}, "count reset");
    reg_read(DPD_OFS_RPL, d);
    check({8'h00, d}, {14'h0000, DPD_RST_RPL}, "rpl reset");
    reg_write(DPD_OFS_STATUS, 8'hFF);
    wait_status(8'h01);
    check({1'b0, mem_ctl}, {1'b0, mem_normal}, "mem pins normal");
    $display("test reset done");
  endtask : test_reset

  task automatic test_regs();
    logic [7:0] d;
    reg_write(DPD_OFS_RPL, 8'hFF);
    reg_read(DPD_OFS_RPL, d);
    check({8'h00, d}, 16'h0003, "rpl readback");
    check({14'h0000, burst}, 16'h0002, "two per line");
    reg_write(DPD_OFS_RPL, 8'h01);
    reg_write(DPD_OFS_COUNT, 8'hA5);
    reg_read(DPD_OFS_COUNT, d);
    check({8'h00, d}, 16'h00A5, "count readback");
    check({14'h0000, burst}, 16'h0001, "one per line");
    reg_write(DPD_OFS_COUNT, 8'h00);
    $display("test regs done");
  endtask : test_regs

  task automatic test_idle();
    int ones;
    int cbrs;
    pd_cmd <= 1'b1;
    wait_status(8'h90);
    check({disp_on, dac_on, arb_en, io_ok, mem_ok}, 16'h0002, "idle levels");
    en_ones(ones);
    check(ones[15:0], 16'h0002, "idle divide");
    cbrs = 0;
    repeat (90) begin
      @(posedge core_clk_i);
      #1;
      if (cbr === 1'b1) cbrs++;
    end
    check(16'(cbrs >= 2), 16'h0001, "idle cbr");
    pd_cmd <= 1'b0;
    wait_status(8'h01);
    check({disp_on, dac_on, mem_ok, clk_en}, 16'h000F, "idle exit");
    $display("test idle done");
  endtask : test_idle

  task automatic test_sleep();
    int lines;
    int n;
    int cbrs;
    reg_write(DPD_OFS_MODE, 8'hC0);
    reg_write(DPD_OFS_COUNT, 8'h80);
    pd_cmd <= 1'b1;
    n = 0;
    while (io_ok !== 1'b0 && n < 100) begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    check({io_ok, mem_ok, disp_on, src_cnt}, 16'h0000, "sleep lockout");
    lines = 0;
    n = 0;
    while (clk_en !== 1'b0 && n < 600) begin
      @(posedge core_clk_i);
      #1;
      if (line_end === 1'b1) lines++;
      n++;
    end
    check(16'(lines >= 4), 16'h0001, "entry lines");
    check({15'h0000, clk_en}, 16'h0000, "clock stop");
    cbrs = 0;
    repeat (100) begin
      @(posedge core_clk_i);
      #1;
      if (cbr === 1'b1) cbrs++;
    end
    check(16'(cbrs >= 2), 16'h0001, "sleep cbr");
    check({dac_on, io_ok, clk_en}, 16'h0000, "sleep dac");
    check({1'b0, mem_ctl}, 16'h7FFF, "sleep pins");
    pd_cmd <= 1'b0;
    lines = 0;
    n = 0;
    while (io_ok !== 1'b1 && n < 600) begin
      @(posedge core_clk_i);
      #1;
      if (line_end === 1'b1) lines++;
      n++;
    end
    check(16'(lines >= 4), 16'h0001, "exit lines");
    wait_status(8'h01);
    check({disp_on, clk_en}, 16'h0003, "sleep exit");
    // The host sets its registers up again once sleep is over.
    reg_write(DPD_OFS_MODE, 8'h00);
    reg_write(DPD_OFS_COUNT, 8'h00);
    $display("test sleep done");
  endtask : test_sleep

  task automatic test_general(input logic [7:0] mode, input logic [7:0] cnt,
                              input logic [7:0] st, input int ones_exp, input int gap_exp);
    int ones;
    int n;
    reg_write(DPD_OFS_MODE, mode);
    reg_write(DPD_OFS_COUNT, cnt);
    pd_cmd <= 1'b1;
    wait_status(st);
    check({src_cnt, io_ok, mem_ok, disp_on, dac_on}, 16'h001C, "general levels");
    en_ones(ones);
    check(ones[15:0], ones_exp[15:0], "general divide");
    gap(n);
    gap(n);
    check(n[15:0], gap_exp[15:0], "count timer");
    pd_cmd <= 1'b0;
    wait_status(8'h01);
    en_ones(ones);
    check(ones[15:0], 16'd16, "full clock");
    reg_write(DPD_OFS_MODE, 8'h00);
    reg_write(DPD_OFS_COUNT, 8'h00);
    $display("test general done");
  endtask : test_general

  // Prints the verdict and ends the run.
  task automatic complete_run();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  // Main sequence.
  initial begin
    errors     = 0;
    compares   = 0;
    resetn_i   = 1'b0;
    pd_cmd     = 1'b0;
    mem_normal = 15'h0A5C;
    reg_addr   = 2'h0;
    reg_wdata  = 8'h00;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    repeat (3) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    test_reset();
    test_regs();
    test_idle();
    test_sleep();
    test_general(8'h00, 8'h82, 8'hA0, 16, 56);
    test_general(8'h40, 8'h80, 8'hC0, 2, 320);
    complete_run();
  end

  // Watchdog against a hang: the tests need well under 20000 cycles.
  initial begin
    #200000;
    errors++;
    complete_run();
  end
endmodule : dpd_power_down_control_bench
